// File: psr_pkg.sv
// Shared constants and types of the pressure sensor readout block.
// Assumes a single 100 MHz system clock.
package psr_pkg;
   localparam int PSR_BRIDGE_W = 14;
   localparam int PSR_TEMP_W = 11;
   localparam int PSR_PKT_BITS = 32;
   localparam int PSR_PAD_BITS = 5;
   localparam int PSR_CNT_W = 6;
   localparam int PSR_SYNC_STAGES = 3;
   localparam logic [1:0] PSR_STATUS_VALID = 2'h0;
   localparam logic [1:0] PSR_STATUS_STALE = 2'h2;
   localparam logic [5:0] PSR_CNT_RST = 6'h00;
   localparam logic [5:0] PSR_CNT_FULL = 6'h20;
   // Clock rate and phase times of a measurement cycle.
   localparam int PSR_CLK_MHZ = 100;
   localparam int PSR_TEMP_US = 500;
   localparam int PSR_AZ_US = 500;
   localparam int PSR_BRIDGE_US = 400;
   localparam int PSR_CORR_US = 100;
   localparam int PSR_TEMP_CYC = PSR_TEMP_US * PSR_CLK_MHZ;
   localparam int PSR_AZ_CYC = PSR_AZ_US * PSR_CLK_MHZ;
   localparam int PSR_BRIDGE_CYC = PSR_BRIDGE_US * PSR_CLK_MHZ;
   localparam int PSR_CORR_CYC = PSR_CORR_US * PSR_CLK_MHZ;
   localparam int PSR_PHASE_W = 20;
   // Front-end select codes.
   localparam logic [1:0] PSR_SEL_TEMP = 2'h0;
   localparam logic [1:0] PSR_SEL_AZ = 2'h1;
   localparam logic [1:0] PSR_SEL_BRIDGE = 2'h2;
   typedef enum logic [2:0] {
      PSR_SLEEP,
      PSR_TEMP,
      PSR_AZ,
      PSR_BRIDGE,
      PSR_CORR
   } psr_seq_state_t;
endpackage : psr_pkg

// File: psr_res_if.sv
// Result carrier between the measurement sequencer and the readout core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface psr_res_if;
   logic done;
   logic busy;
   logic [13:0] bridge;
   logic [10:0] temp;
   modport seq (output done, output busy, output bridge, output temp);
   modport core (input done, input busy, input bridge, input temp);
endinterface : psr_res_if

// File: psr_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes the input is asynchronous to clk_i.
`timescale 1ns/1ns
module psr_sync #(
   parameter logic RST_VAL = 1'b0
) (
   // System.
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Pin and filtered level.
   input wire logic pin_i,
   output logic level_o
);
   logic [2:0] ff_q;
   logic level_q;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ff_q <= {3{RST_VAL}};
      end else begin
         ff_q <= {ff_q[1:0], pin_i};
      end
   end

   // A change counts only once stages two and three agree.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         level_q <= RST_VAL;
      end else if (ff_q[1] == ff_q[2]) begin
         level_q <= ff_q[2];
      end
   end

   assign level_o = level_q;
endmodule : psr_sync

// File: psr_meas.sv
// Sleep-mode measurement sequencer and correction.
// Assumes the analog front end presents a settled code on adc_data_i.
`timescale 1ns/1ns
module psr_meas #(
   parameter int TEMP_CYC = psr_pkg::PSR_TEMP_CYC,
   parameter int AZ_CYC = psr_pkg::PSR_AZ_CYC,
   parameter int BRIDGE_CYC = psr_pkg::PSR_BRIDGE_CYC,
   parameter int CORR_CYC = psr_pkg::PSR_CORR_CYC
) (
   // System.
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Requests.
   input wire logic full_req_i,
   input wire logic bridge_req_i,
   // Front end.
   input wire logic [13:0] adc_data_i,
   output logic [1:0] adc_sel_o,
   // Results.
   psr_res_if.seq res
);
   localparam int W = psr_pkg::PSR_PHASE_W;
   psr_pkg::psr_seq_state_t state_q;
   logic [W-1:0] cnt_q;
   logic [10:0] temp_q;
   logic [13:0] az_q;
   logic [13:0] raw_q;
   logic end_w;

   assign end_w = (cnt_q == '0);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= psr_pkg::PSR_SLEEP;
         cnt_q <= '0;
      end else begin
         unique case (state_q)
            psr_pkg::PSR_SLEEP: begin
               if (full_req_i) begin
                  state_q <= psr_pkg::PSR_TEMP;
                  cnt_q <= W'(TEMP_CYC - 1);
               end else if (bridge_req_i) begin
                  state_q <= psr_pkg::PSR_BRIDGE;
                  cnt_q <= W'(BRIDGE_CYC - 1);
               end
            end
            psr_pkg::PSR_TEMP: begin
               if (end_w) begin
                  state_q <= psr_pkg::PSR_AZ;
                  cnt_q <= W'(AZ_CYC - 1);
               end else cnt_q <= cnt_q - 1'b1;
            end
            psr_pkg::PSR_AZ: begin
               if (end_w) begin
                  state_q <= psr_pkg::PSR_BRIDGE;
                  cnt_q <= W'(BRIDGE_CYC - 1);
               end else cnt_q <= cnt_q - 1'b1;
            end
            psr_pkg::PSR_BRIDGE: begin
               if (end_w) begin
                  state_q <= psr_pkg::PSR_CORR;
                  cnt_q <= W'(CORR_CYC - 1);
               end else cnt_q <= cnt_q - 1'b1;
            end
            psr_pkg::PSR_CORR: begin
               if (end_w) state_q <= psr_pkg::PSR_SLEEP;
               else cnt_q <= cnt_q - 1'b1;
            end
            default: state_q <= psr_pkg::PSR_SLEEP;
         endcase
      end
   end

   // Stored temperature and zero persist so a bridge-only cycle reuses them.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         temp_q <= '0;
         az_q <= '0;
         raw_q <= '0;
      end else if (end_w) begin
         if (state_q == psr_pkg::PSR_TEMP) temp_q <= adc_data_i[13:3];
         if (state_q == psr_pkg::PSR_AZ) az_q <= adc_data_i;
         if (state_q == psr_pkg::PSR_BRIDGE) raw_q <= adc_data_i;
      end
   end

   // Correction removes the zero offset, clamped to the 14-bit code range.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         res.done <= 1'b0;
         res.bridge <= '0;
         res.temp <= '0;
      end else begin
         res.done <= 1'b0;
         if (state_q == psr_pkg::PSR_CORR && end_w) begin
            res.done <= 1'b1;
            res.bridge <= (raw_q > az_q) ? raw_q - az_q : 14'h0000;
            res.temp <= temp_q;
         end
      end
   end

   assign res.busy = (state_q != psr_pkg::PSR_SLEEP) | res.done;
   assign adc_sel_o = (state_q == psr_pkg::PSR_TEMP) ? psr_pkg::PSR_SEL_TEMP :
      (state_q == psr_pkg::PSR_AZ) ? psr_pkg::PSR_SEL_AZ : psr_pkg::PSR_SEL_BRIDGE;

   AST_FULL_ORDER: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(state_q == psr_pkg::PSR_AZ) |-> $past(state_q) == psr_pkg::PSR_TEMP)
      else $error("offset zeroing not preceded by temperature");
   AST_BRIDGE_ONLY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      state_q == psr_pkg::PSR_SLEEP && bridge_req_i && !full_req_i |=> state_q == psr_pkg::PSR_BRIDGE)
      else $error("bridge-only request did not go to bridge phase");
   AST_STAY_ASLEEP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      state_q == psr_pkg::PSR_SLEEP && !full_req_i && !bridge_req_i |=> state_q == psr_pkg::PSR_SLEEP)
      else $error("woke without a request");
endmodule : psr_meas

// File: psr_top.sv
// Read-only serial readout of a compensated pressure and temperature sensor.
// Assumes SCLK idles low and is far slower than clk_i; requests on the
// command inputs are one-cycle pulses from same-clock decode logic.
`timescale 1ns/1ns

// How it works
// - The serial link only transmits on MISO; nothing is ever taken in.
// - MISO changes after each falling SCLK edge.
// - A full packet is four bytes, 32 bits, under one select.
// - Bytes one and two carry the upper and lower bridge bytes.
// - Byte three holds temperature bits 10..3, byte four bits 2..0 on top.
// - The low five bits of byte four are filler the master discards.
// - A read cut short after two or three bytes is fine.
// - The corrected bridge is a 14-bit unsigned code.
// - After sleep entry the part stays idle until a measure request.
// - A full request measures temperature, zero, bridge, then corrects.
// - A bridge-only request reuses stored temperature and zero values.
// - Finished results load into the output register, then sleep again.
// - A fetch returns 2, 3 or 4 bytes without waking the part.
// - The first fetch after a measurement shows the new result as valid, unless a fetch opened during the cycle closed after it ended.
// - After a fetch the status turns stale until the next cycle.
// - A fetch during a running cycle reports stale.
// - Data are not trustworthy before the first full measurement.
// - In two-wire mode the select pin signals data ready.
module psr_top #(
   parameter int TEMP_CYC = psr_pkg::PSR_TEMP_CYC,
   parameter int AZ_CYC = psr_pkg::PSR_AZ_CYC,
   parameter int BRIDGE_CYC = psr_pkg::PSR_BRIDGE_CYC,
   parameter int CORR_CYC = psr_pkg::PSR_CORR_CYC
) (
   // System.
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Serial link pins.
   input wire logic sclk_i,
   input wire logic ss_n_i,
   output logic miso_o,
   output logic miso_oe_o,
   // Mode and command decode.
   input wire logic i2c_mode_i,
   input wire logic full_measure_request_i,
   input wire logic bridge_only_measure_request_i,
   // Analog front end.
   input wire logic [13:0] adc_data_i,
   output logic [1:0] adc_sel_o,
   // Status.
   output logic data_ready_o,
   output logic sleep_o
);
   psr_res_if res ();

   logic sclk_s;
   logic ss_n_s;
   logic sclk_p_q;
   logic ss_p_q;
   logic sclk_fall;
   logic ss_fall;
   logic ss_rise;
   logic spi_en;
   logic active_q;
   logic [5:0] cnt_q;
   logic [31:0] sh_q;
   logic [13:0] out_bridge_q;
   logic [10:0] out_temp_q;
   logic fresh_q;
   logic drdy_q;
   logic fetch_end;
   logic spi_mr;
   logic full_req;
   logic bridge_req;
   logic [1:0] status;
   logic [31:0] packet;

   // Pin synchronisers; SCLK idles low, select idles high.
   psr_sync #(
      .RST_VAL(1'b0)
   ) u_sync_sclk (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .pin_i(sclk_i),
      .level_o(sclk_s)
   );

   psr_sync #(
      .RST_VAL(1'b1)
   ) u_sync_ss (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .pin_i(ss_n_i),
      .level_o(ss_n_s)
   );

   psr_meas #(
      .TEMP_CYC(TEMP_CYC),
      .AZ_CYC(AZ_CYC),
      .BRIDGE_CYC(BRIDGE_CYC),
      .CORR_CYC(CORR_CYC)
   ) u_meas (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .full_req_i(full_req),
      .bridge_req_i(bridge_req),
      .adc_data_i(adc_data_i),
      .adc_sel_o(adc_sel_o),
      .res(res.seq)
   );

   // Edge detection on the filtered pin levels.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sclk_p_q <= 1'b0;
         ss_p_q <= 1'b1;
      end else begin
         sclk_p_q <= sclk_s;
         ss_p_q <= ss_n_s;
      end
   end

   // In two-wire mode the select pin is an output, so framing is ignored.
   assign spi_en = !i2c_mode_i;
   assign sclk_fall = sclk_p_q && !sclk_s;
   assign ss_fall = spi_en && ss_p_q && !ss_n_s;
   assign ss_rise = !ss_p_q && ss_n_s;

   // A frame with no clocks is a wake request; one with clocks is a fetch.
   assign fetch_end = ss_rise && active_q && (cnt_q != psr_pkg::PSR_CNT_RST);
   assign spi_mr = ss_rise && active_q && (cnt_q == psr_pkg::PSR_CNT_RST);
   assign full_req = full_measure_request_i || spi_mr;
   // Bridge-only requests exist on the two-wire interface only.
   assign bridge_req = bridge_only_measure_request_i && i2c_mode_i;

   // Status reflects freshness at the moment the frame opens.
   assign status = (fresh_q && !res.busy) ? psr_pkg::PSR_STATUS_VALID :
      psr_pkg::PSR_STATUS_STALE;
   assign packet = {status, out_bridge_q, out_temp_q, {psr_pkg::PSR_PAD_BITS{1'b0}}};

   // Output data register, loaded only when a cycle completes.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         out_bridge_q <= '0;
         out_temp_q <= '0;
      end else if (res.done) begin
         out_bridge_q <= res.bridge;
         out_temp_q <= res.temp;
      end
   end

   // Freshness: a completed cycle wins over a fetch ending in the same cycle.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fresh_q <= 1'b0;
      end else if (res.done) begin
         fresh_q <= 1'b1;
      end else if (fetch_end) begin
         fresh_q <= 1'b0;
      end
   end

   // Data-ready flag for two-wire mode; cleared when a new cycle is requested.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         drdy_q <= 1'b0;
      end else if (res.done && i2c_mode_i) begin
         drdy_q <= 1'b1;
      end else if (full_req || bridge_req || !i2c_mode_i) begin
         drdy_q <= 1'b0;
      end
   end

   // Frame state: open on select fall, closed on select rise.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         active_q <= 1'b0;
      end else if (ss_fall) begin
         active_q <= 1'b1;
      end else if (ss_n_s || !spi_en) begin
         active_q <= 1'b0;
      end
   end

   // Bit counter, saturating at a full packet.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= psr_pkg::PSR_CNT_RST;
      end else if (ss_fall || ss_rise) begin
         cnt_q <= psr_pkg::PSR_CNT_RST;
      end else if (active_q && sclk_fall && cnt_q != psr_pkg::PSR_CNT_FULL) begin
         cnt_q <= cnt_q + 6'h01;
      end
   end

   // Transmit shifter; the first bit sits on MISO before the first rise.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sh_q <= '0;
      end else if (ss_fall) begin
         sh_q <= packet;
      end else if (active_q && sclk_fall && cnt_q != psr_pkg::PSR_CNT_FULL) begin
         sh_q <= {sh_q[30:0], 1'b0};
      end
   end

   // The pin is only ever driven outward, and only inside a frame.
   assign miso_o = sh_q[31];
   assign miso_oe_o = active_q;
   assign data_ready_o = drdy_q;
   assign sleep_o = !res.busy;

   sequence s_frame_open;
      $fell(ss_n_s) && spi_en;
   endsequence

   sequence s_fetch_close;
      ss_rise && active_q && cnt_q != psr_pkg::PSR_CNT_RST;
   endsequence

   AST_MISO_ONE_WAY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      miso_oe_o |-> !ss_n_s || $past(!ss_n_s))
      else $error("MISO driven outside a frame");
   AST_SHIFT_ON_FALL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      active_q && sclk_fall && !ss_rise && cnt_q < psr_pkg::PSR_CNT_FULL |=> sh_q == {$past(sh_q[30:0]), 1'b0})
      else $error("MISO did not advance after SCLK fall");
   AST_HOLD_ON_RISE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      active_q && !sclk_fall && !ss_fall |=> $stable(sh_q))
      else $error("MISO changed away from a falling edge");
   AST_COUNT_LIMIT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      cnt_q <= psr_pkg::PSR_CNT_FULL)
      else $error("bit counter ran past 32");
   AST_BYTE_MAP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_frame_open |=> sh_q[29:16] == out_bridge_q && sh_q[15:5] == out_temp_q)
      else $error("packet fields misplaced");
   AST_STALE_AFTER_FETCH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_fetch_close and !res.done |=> !fresh_q)
      else $error("status not stale after fetch");
   AST_BUSY_STALE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_frame_open and res.busy |=> sh_q[31:30] == psr_pkg::PSR_STATUS_STALE)
      else $error("fetch during measurement not stale");
   AST_FIRST_VALID: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      res.done ##1 (!res.busy && !fetch_end) [*1] ##1 s_frame_open |=>
      sh_q[31:30] == psr_pkg::PSR_STATUS_VALID)
      else $error("first fetch after result not valid");
   AST_LOAD_RESULT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      res.done |=> out_bridge_q == $past(res.bridge) && out_temp_q == $past(res.temp))
      else $error("result register not loaded");
   AST_RELEASE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ss_rise |=> !miso_oe_o && cnt_q == psr_pkg::PSR_CNT_RST)
      else $error("select rise did not release MISO");
   AST_DATA_READY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      res.done && i2c_mode_i |=> data_ready_o)
      else $error("data ready did not rise");
   AST_NO_WAKE_ON_FETCH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_fetch_close and (!full_measure_request_i && !bridge_req && sleep_o) |=> sleep_o)
      else $error("fetch woke the sensor");
endmodule : psr_top

// File: psr_master_model.sv
// Serial bus master model that reads the sensor over the select, clock and data pins.
// Assumes a 1 ns time unit and a sensor that releases the data pin between frames.
`timescale 1ns/1ns
module psr_master_model #(
   parameter int HALF_NS = 640,
   parameter int SETUP_NS = 2600,
   parameter int FREE_NS = 2200
) (
   // Sensor data pin and its enable.
   input wire logic miso_i,
   input wire logic miso_oe_i,
   // Link pins driven by the master.
   output logic sclk_o,
   output logic ss_n_o
);
   initial begin
      sclk_o = 1'b0;
      ss_n_o = 1'b1;
   end

   // Reads nbytes bytes; a frame with no bytes carries no clock edges at all.
   // A released data pin reads as the inverse of the last bit seen.
   task automatic frame(input int nbytes, output logic [31:0] word);
      logic line;
      logic last;
      word = 32'h00000000;
      last = 1'b0;
      #3;
      ss_n_o = 1'b0;
      #(SETUP_NS);
      for (int i = 0; i < nbytes * 8; i++) begin
         #(HALF_NS);
         sclk_o = 1'b1;
         line = miso_oe_i ? miso_i : ~last;
         word[31 - i] = line;
         last = line;
         #(HALF_NS);
         sclk_o = 1'b0;
      end
      #(HALF_NS);
      ss_n_o = 1'b1;
      word = word & 32'hFFFFFFE0;
      #(FREE_NS);
   endtask : frame
endmodule : psr_master_model

// File: test_pressure_sensor_spi_readout.sv
// Self-checking bench of the pressure sensor readout top level.
// Assumes the serial master model and shortened measurement phases.
`timescale 1ns/1ns
module test_pressure_sensor_spi_readout;
   localparam int TC = 400;
   localparam int AC = 400;
   localparam int BC = 320;
   localparam int CC = 80;
   logic clk_i, rst_n_i, sclk_i, ss_n_i, miso_o, miso_oe_o, i2c_mode_i;
   logic full_req_i, bonly_req_i, data_ready_o, sleep_o;
   logic [13:0] adc_data_i, t_code, z_code, b_code;
   logic [1:0] adc_sel_o;
   logic [31:0] w;
   int failures, checks_done, cycles;
   int sel_cnt [3];

   psr_top #(.TEMP_CYC(TC), .AZ_CYC(AC), .BRIDGE_CYC(BC), .CORR_CYC(CC)) DUT (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i), .ss_n_i(ss_n_i),
      .miso_o(miso_o), .miso_oe_o(miso_oe_o), .i2c_mode_i(i2c_mode_i),
      .full_measure_request_i(full_req_i), .bridge_only_measure_request_i(bonly_req_i),
      .adc_data_i(adc_data_i), .adc_sel_o(adc_sel_o), .data_ready_o(data_ready_o), .sleep_o(sleep_o));

   psr_master_model master (.miso_i(miso_o), .miso_oe_i(miso_oe_o), .sclk_o(sclk_i), .ss_n_o(ss_n_i));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // Front end answers the quantity that the sequencer selects.
   always @(negedge clk_i) begin
      adc_data_i <= (adc_sel_o === 2'h0) ? t_code : (adc_sel_o === 2'h1) ? z_code : b_code;
   end

   always @(posedge clk_i) begin
      cycles++;
      if (sleep_o === 1'b0 && adc_sel_o !== 2'h3) begin
         sel_cnt[adc_sel_o]++;
      end
      if (cycles == 90000) begin
         failures++;
         $display("[FAIL] run length expected below 90000 cycles seen 90000");
         end_of_test();
      end
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic pulse(input logic full);
      @(negedge clk_i);
      full_req_i = full;
      bonly_req_i = ~full;
      @(negedge clk_i);
      full_req_i = 1'b0;
      bonly_req_i = 1'b0;
   endtask : pulse

   task automatic wait_done();
      int n;
      n = 0;
      while (sleep_o !== 1'b1 && n < 5000) begin
         @(negedge clk_i);
         n++;
      end
      chk("sleep after cycle", 32'h1, {31'h0, sleep_o});
   endtask : wait_done

   task automatic fetch(input int n);
      master.frame(n, w);
      chk("data enable after frame", 32'h0, {31'h0, miso_oe_o});
   endtask : fetch

   task automatic t_reset();
      chk("enable at reset", 32'h0, {31'h0, miso_oe_o});
      chk("sleep at reset", 32'h1, {31'h0, sleep_o});
      chk("ready at reset", 32'h0, {31'h0, data_ready_o});
      fetch(2);
      chk("status before first cycle", 32'h2, {30'h0, w[31:30]});
   endtask : t_reset

   task automatic t_frame_measure();
      t_code = 14'h2ABC;
      z_code = 14'h0100;
      b_code = 14'h2100;
      sel_cnt = '{0, 0, 0};
      master.frame(0, w);
      chk("wake on empty frame", 32'h0, {31'h0, sleep_o});
      wait_done();
      chk("temperature phase", TC, sel_cnt[0]);
      chk("zeroing phase", AC, sel_cnt[1]);
      chk("bridge phase", 32'h1, {31'h0, sel_cnt[2] >= BC + CC && sel_cnt[2] <= BC + CC + 2});
      fetch(4);
      chk("full packet", {2'b00, 14'h2000, 11'h557, 5'h00}, w);
      fetch(3);
      chk("three byte packet", {2'b10, 14'h2000, 8'hAA, 8'h00}, w);
   endtask : t_frame_measure

   task automatic t_full_scale();
      t_code = 14'h0008;
      z_code = 14'h0000;
      b_code = 14'h3FFF;
      pulse(1'b1);
      wait_done();
      fetch(2);
      chk("two byte packet", {2'b00, 14'h3FFF, 16'h0000}, w);
      fetch(4);
      chk("restart at first byte", {2'b10, 14'h3FFF, 11'h001, 5'h00}, w);
   endtask : t_full_scale

   task automatic t_clamp_busy();
      z_code = 14'h0200;
      b_code = 14'h0100;
      pulse(1'b1);
      fetch(2);
      chk("status during cycle", 32'h2, {30'h0, w[31:30]});
      wait_done();
      fetch(4);
      chk("bridge clamped at zero", 32'h0, {18'h0, w[29:16]});
   endtask : t_clamp_busy

   task automatic t_bridge_only();
      b_code = 14'h0300;
      pulse(1'b0);
      @(negedge clk_i);
      chk("bridge request outside two-wire", 32'h1, {31'h0, sleep_o});
      i2c_mode_i = 1'b1;
      sel_cnt = '{0, 0, 0};
      pulse(1'b0);
      chk("bridge request wakes", 32'h0, {31'h0, sleep_o});
      wait_done();
      chk("no temperature phase", 32'h0, sel_cnt[0]);
      chk("no zeroing phase", 32'h0, sel_cnt[1]);
      chk("ready raised", 32'h1, {31'h0, data_ready_o});
      master.frame(0, w);
      chk("link ignored in two-wire", 32'h1, {31'h0, sleep_o});
      chk("pin undriven in two-wire", 32'h0, {31'h0, miso_oe_o});
      @(negedge clk_i);
      i2c_mode_i = 1'b0;
      repeat (2) @(negedge clk_i);
      chk("ready cleared", 32'h0, {31'h0, data_ready_o});
      fetch(4);
      chk("stored zero reused", {2'b00, 14'h0100, 11'h001, 5'h00}, w);
   endtask : t_bridge_only

   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_of_test

   initial begin
      rst_n_i = 1'b0;
      i2c_mode_i = 1'b0;
      full_req_i = 1'b0;
      bonly_req_i = 1'b0;
      t_code = 14'h0000;
      z_code = 14'h0000;
      b_code = 14'h0000;
      adc_data_i = 14'h0000;
      failures = 0;
      checks_done = 0;
      cycles = 0;
      repeat (3) @(negedge clk_i);
      rst_n_i = 1'b1;
      repeat (4) @(negedge clk_i);
      t_reset();
      t_frame_measure();
      t_full_scale();
      t_clamp_busy();
      t_bridge_only();
      end_of_test();
   end
endmodule : test_pressure_sensor_spi_readout
